// ===== design/pis_irq_ctrl.sv
// Overview of operation
// - Three Hall flags belong to group 0, set by selected filtered edges.
// - Hall edge select picks rising, falling, both, or disables Hall requests.
// - Group 0 vectors only with global, group 0 and Hall source enables.
// - Group 0 service clears global enable and group flag, keeps Hall flags.
// - External pin flag set by selected edge; select may disable it.
// - External vectors with global and own enable; service clears flag, global.
// - Comparator 0 flag set by edge chosen in comparator edge field.
// - Comparator 0 vectors when enabled; service clears flag and global enable.
// - Filter input flag set by selected pin edge, or disabled.
// - Filter input vectors when enabled; service clears flag and global enable.
// - Low-voltage flag set on low supply; vectors, auto-clears when enabled.
// - Motor trip flag set on trip; vectors and auto-clears when enabled.
// - Serial request raised by any of six serial conditions.
// - Serial service clears serial flag and global enable, not serial status.
// - EEPROM flag set at cycle end; vectors and auto-clears when enabled.
// - Tick flag set on each time-base overflow; vectors, auto-clears.
// - Tick clock is system, system over four, or subsidiary, then divided.
// - No vector call while return stack is full; request waits.
// - Tick period is 2^8 to 2^15 prescaled clocks by three-bit code.
// - Source field 00 system, 01 system over four, 1x subsidiary.
// - Flags set regardless of enable; global enable off blocks all.
// - Any set flag raises the wake request.
`timescale 1ns/1ps
`default_nettype none

module pis_irq_ctrl (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Asynchronous pins and analog outputs
    input  wire logic       ext_pin,
    input  wire logic       filter_input_pin,
    input  wire logic       current_cmp_event,
    input  wire logic       subsidiary_clock,
    // Same-clock event sources
    input  wire logic       hall_filtered_a,
    input  wire logic       hall_filtered_b,
    input  wire logic       hall_filtered_c,
    input  wire logic       low_voltage_detect,
    input  wire logic       motor_trip_signal,
    input  wire logic [5:0] serial_conditions,
    input  wire logic       eeprom_cycle_done,
    // Edge and time-base configuration
    input  wire logic [1:0] hall_edge_select_reg,
    input  wire logic [1:0] ext_edge_select_reg,
    input  wire logic [1:0] cmp_edge_field,
    input  wire logic [1:0] filter_edge_field,
    input  wire logic       periodic_tick_control,
    input  wire logic [2:0] tick_period_field,
    input  wire logic [1:0] prescaler_source_field,
    // Enables
    input  wire logic       gie_write,
    input  wire logic       gie_wdata,
    input  wire logic       group0_enable,
    input  wire logic       hall_a_enable,
    input  wire logic       hall_b_enable,
    input  wire logic       hall_c_enable,
    input  wire logic       ext_pin_enable,
    input  wire logic       cmp_zero_enable,
    input  wire logic       filter_input_enable,
    input  wire logic       low_voltage_enable,
    input  wire logic       motor_trip_enable,
    input  wire logic       serial_irq_enable,
    input  wire logic       eeprom_done_enable,
    input  wire logic       tick_irq_enable,
    // Software flag writes
    input  wire logic [11:0] flag_set,
    input  wire logic [11:0] flag_clear,
    // Processor core
    input  wire logic       stack_full,
    input  wire logic       irq_ack,
    output logic            irq_request,
    output logic [3:0]      irq_vector,
    output logic            wake_request,
    // Status
    output logic            global_irq_enable,
    output logic            hall_a_flag,
    output logic            hall_b_flag,
    output logic            hall_c_flag,
    output logic            group0_flag,
    output logic            ext_pin_flag,
    output logic            cmp_zero_flag,
    output logic            filter_input_flag,
    output logic            low_voltage_flag,
    output logic            motor_trip_flag,
    output logic            serial_irq_flag,
    output logic            eeprom_done_flag,
    output logic            tick_flag
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam int PIN_W   = 4;
    localparam int PIN_EXT = 3;
    localparam int PIN_FLT = 2;
    localparam int PIN_CMP = 1;
    localparam int PIN_SUB = 0;

    logic [PIN_W-1:0]              sync_a;
    logic [PIN_W-1:0]              sync_b;
    logic [PIN_W-1:0]              pin_prev;
    logic [PIN_W-1:0]              next_sync_a;
    logic [PIN_W-1:0]              next_sync_b;
    logic [PIN_W-1:0]              next_pin_prev;
    logic [pis_pkg::NUM_HALL-1:0]  hall_now;
    logic [pis_pkg::NUM_HALL-1:0]  hall_prev;
    logic [pis_pkg::NUM_HALL-1:0]  next_hall_prev;
    logic [pis_pkg::NUM_HALL-1:0]  hall_en;
    logic [pis_pkg::NUM_HALL-1:0]  hall_set;
    logic                          serial_prev;
    logic                          lowv_prev;
    logic                          trip_prev;
    logic                          next_serial_prev;
    logic                          next_lowv_prev;
    logic                          next_trip_prev;
    logic                          serial_any;
    logic                          ext_set;
    logic                          cmp_set;
    logic [pis_pkg::FLAG_W-1:0]    flags;
    logic [pis_pkg::FLAG_W-1:0]    next_flags;
    logic [pis_pkg::FLAG_W-1:0]    set_vec;
    logic [pis_pkg::FLAG_W-1:0]    svc_clr;
    logic [pis_pkg::NUM_SRC-1:0]   src_flag;
    logic [pis_pkg::NUM_SRC-1:0]   src_en;
    logic [pis_pkg::NUM_SRC-1:0]   req;
    logic [pis_pkg::NUM_SRC-1:0]   svc_src;
    logic                          service;
    logic                          next_gie;
    logic                          next_irq_request;
    logic [pis_pkg::VEC_W-1:0]     next_irq_vector;
    logic                          next_wake;

    pis_tick_if tb_if ();

    assign hall_now = {hall_filtered_c, hall_filtered_b, hall_filtered_a};
    assign hall_en  = {hall_c_enable, hall_b_enable, hall_a_enable};

    // ----------------------------------------------------------------
    // Time base divider
    // ----------------------------------------------------------------
    assign tb_if.tick_on   = periodic_tick_control;
    assign tb_if.period    = tick_period_field;
    assign tb_if.source    = prescaler_source_field;
    assign tb_if.sub_level = sync_b[PIN_SUB];

    pis_tick_divider u_tick (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .tb       (tb_if.divider)
    );

    // ----------------------------------------------------------------
    // Input capture and edge detection
    // ----------------------------------------------------------------
    // Pin edges are taken after the second stage, so metastability stays out.
    always_comb begin
        next_sync_a = {ext_pin, filter_input_pin, current_cmp_event,
                       subsidiary_clock};
        next_sync_b      = sync_a;
        next_pin_prev    = sync_b;
        next_hall_prev   = hall_now;
        serial_any       = |serial_conditions;
        next_serial_prev = serial_any;
        next_lowv_prev   = low_voltage_detect;
        next_trip_prev   = motor_trip_signal;
        for (int i = 0; i < pis_pkg::NUM_HALL; i++) begin
            hall_set[i] = pis_pkg::edge_hit(hall_prev[i], hall_now[i],
                                            hall_edge_select_reg);
        end
        ext_set = pis_pkg::edge_hit(pin_prev[PIN_EXT], sync_b[PIN_EXT],
                                    ext_edge_select_reg);
        cmp_set = pis_pkg::edge_hit(pin_prev[PIN_CMP], sync_b[PIN_CMP],
                                    cmp_edge_field);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a      <= 4'h0;
            sync_b      <= 4'h0;
            pin_prev    <= 4'h0;
            hall_prev   <= 3'h0;
            serial_prev <= 1'b0;
            lowv_prev   <= 1'b0;
            trip_prev   <= 1'b0;
        end else begin
            sync_a      <= next_sync_a;
            sync_b      <= next_sync_b;
            pin_prev    <= next_pin_prev;
            hall_prev   <= next_hall_prev;
            serial_prev <= next_serial_prev;
            lowv_prev   <= next_lowv_prev;
            trip_prev   <= next_trip_prev;
        end
    end

    // ----------------------------------------------------------------
    // Flags, global enable and vector request
    // ----------------------------------------------------------------
    always_comb begin
        set_vec = '0;
        set_vec[pis_pkg::NUM_HALL-1:0] = hall_set;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_GROUP0] = |hall_set;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_EXT]    = ext_set;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_CMP]    = cmp_set;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_FILTER] =
            pis_pkg::edge_hit(pin_prev[PIN_FLT], sync_b[PIN_FLT],
                              filter_edge_field);
        // Level sources set on onset so an auto-clear is not undone at once.
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_LOWV] =
            low_voltage_detect & ~lowv_prev;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_TRIP] =
            motor_trip_signal & ~trip_prev;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_SERIAL] =
            serial_any & ~serial_prev;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_EEPROM] =
            eeprom_cycle_done;
        set_vec[pis_pkg::FL_SRC_BASE + pis_pkg::VEC_TICK] = tb_if.tick;

        service = irq_request & irq_ack;
        svc_src = service ? (pis_pkg::NUM_SRC'(1) << irq_vector) : '0;
        // Service clears the source flag only; Hall flags stay.
        svc_clr = {svc_src, 3'h0};
        // Serial status bits live in the serial block and are untouched.
        next_flags = set_vec | flag_set
                   | (flags & ~flag_clear & ~svc_clr);

        // Service wins over a software write in the same cycle.
        next_gie = gie_write ? gie_wdata : global_irq_enable;
        next_gie = service ? 1'b0 : next_gie;

        src_flag = flags[pis_pkg::FLAG_W-1:pis_pkg::FL_SRC_BASE];
        src_en   = {tick_irq_enable, eeprom_done_enable, serial_irq_enable,
                    motor_trip_enable, low_voltage_enable, filter_input_enable,
                    cmp_zero_enable, ext_pin_enable, group0_enable};
        req = src_flag & src_en;
        req[pis_pkg::VEC_GROUP0] = src_flag[pis_pkg::VEC_GROUP0] & group0_enable
            & |(flags[pis_pkg::NUM_HALL-1:0] & hall_en);

        next_irq_vector = irq_vector;
        for (int i = pis_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                next_irq_vector = pis_pkg::VEC_W'(i);
            end
        end
        next_irq_request = global_irq_enable & (|req) & ~stack_full
                         & ~service;
        next_wake = |flags;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags             <= pis_pkg::FLAGS_RESET;
            global_irq_enable <= 1'b0;
            irq_request       <= 1'b0;
            irq_vector        <= 4'h0;
            wake_request      <= 1'b0;
        end else begin
            flags             <= next_flags;
            global_irq_enable <= next_gie;
            irq_request       <= next_irq_request;
            irq_vector        <= next_irq_vector;
            wake_request      <= next_wake;
        end
    end

    assign hall_a_flag       = flags[pis_pkg::FL_HALL_A];
    assign hall_b_flag       = flags[pis_pkg::FL_HALL_B];
    assign hall_c_flag       = flags[pis_pkg::FL_HALL_C];
    assign group0_flag       = src_flag[pis_pkg::VEC_GROUP0];
    assign ext_pin_flag      = src_flag[pis_pkg::VEC_EXT];
    assign cmp_zero_flag     = src_flag[pis_pkg::VEC_CMP];
    assign filter_input_flag = src_flag[pis_pkg::VEC_FILTER];
    assign low_voltage_flag  = src_flag[pis_pkg::VEC_LOWV];
    assign motor_trip_flag   = src_flag[pis_pkg::VEC_TRIP];
    assign serial_irq_flag   = src_flag[pis_pkg::VEC_SERIAL];
    assign eeprom_done_flag  = src_flag[pis_pkg::VEC_EEPROM];
    assign tick_flag         = src_flag[pis_pkg::VEC_TICK];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_gie_service_clear: assert property (
        service |=> !global_irq_enable)
        else $error("global enable not cleared by service");

    chk_hall_flag_kept: assert property (
        service && irq_vector == 4'h0 && hall_a_flag && !flag_clear[0]
        |=> hall_a_flag)
        else $error("hall flag lost at group service");

    chk_ext_auto_clear: assert property (
        service && irq_vector == 4'h1 && !ext_set && !flag_set[4]
        |=> !ext_pin_flag)
        else $error("external flag not cleared by service");

    chk_ext_edge_sets: assert property (
        ext_set |=> ext_pin_flag)
        else $error("external edge did not set flag");

    chk_cmp_edge_sets: assert property (
        $rose(sync_b[PIN_CMP]) && cmp_edge_field == 2'h1 ##1 1'b1
        |-> cmp_zero_flag)
        else $error("comparator rising edge did not set flag");

    chk_stack_full_block: assert property (
        stack_full |=> !irq_request)
        else $error("request raised while stack full");

    chk_gie_off_block: assert property (
        !global_irq_enable |=> !irq_request)
        else $error("request raised with global enable off");

    chk_cmp_no_enable: assert property (
        !cmp_zero_enable |=> !(irq_request && irq_vector == 4'h2))
        else $error("comparator vectored while disabled");

    chk_tick_sets_flag: assert property (
        tb_if.tick |=> tick_flag)
        else $error("time base tick did not set flag");

    chk_wake_on_flag: assert property (
        (|flags) |=> wake_request)
        else $error("set flag gave no wake request");

    cov_group0_service: cover property (
        service && irq_vector == 4'h0);
    cov_stack_wait: cover property (
        stack_full && global_irq_enable && (|req) ##1 !stack_full ##1
        irq_request);
    cov_tick_vector: cover property (
        tb_if.tick ##[1:3] irq_request && irq_vector == 4'h8);

endmodule

`default_nettype wire

// ===== design/pis_pkg.sv
package pis_pkg;

    // ----------------------------------------------------------------
    // Request sources, in priority order (lowest index served first)
    // ----------------------------------------------------------------
    localparam int NUM_SRC    = 9;
    localparam int VEC_W      = 4;
    localparam int VEC_GROUP0 = 0;
    localparam int VEC_EXT    = 1;
    localparam int VEC_CMP    = 2;
    localparam int VEC_FILTER = 3;
    localparam int VEC_LOWV   = 4;
    localparam int VEC_TRIP   = 5;
    localparam int VEC_SERIAL = 6;
    localparam int VEC_EEPROM = 7;
    localparam int VEC_TICK   = 8;

    // ----------------------------------------------------------------
    // Flag vector layout: three Hall flags, then one flag per source
    // ----------------------------------------------------------------
    localparam int NUM_HALL    = 3;
    localparam int FL_HALL_A   = 0;
    localparam int FL_HALL_B   = 1;
    localparam int FL_HALL_C   = 2;
    localparam int FL_SRC_BASE = 3;
    localparam int FLAG_W      = FL_SRC_BASE + NUM_SRC;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 12'h000;

    // ----------------------------------------------------------------
    // Edge select codes, shared by every edge-triggered source
    // ----------------------------------------------------------------
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    localparam logic [1:0] PSC_SYS      = 2'h0;
    localparam logic [1:0] PSC_SYS_DIV4 = 2'h1;
    localparam int         PSC_SUB_BIT  = 1;
    localparam int         PSC_DIV4     = 4;
    localparam int         TICK_MIN_EXP = 8;
    localparam int         TICK_CNT_W   = 15;

    function automatic logic edge_hit(input logic       prev,
                                      input logic       cur,
                                      input logic [1:0] sel);
        case (sel)
            EDGE_RISE: edge_hit = ~prev & cur;
            EDGE_FALL: edge_hit = prev & ~cur;
            EDGE_BOTH: edge_hit = prev ^ cur;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

endpackage

// ===== design/pis_tick_divider.sv
`timescale 1ns/1ps
`default_nettype none

module pis_tick_divider (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Control from the request logic
    pis_tick_if.divider     tb
);

    logic [1:0]                     div4_cnt;
    logic [1:0]                     next_div4_cnt;
    logic                           sub_prev;
    logic                           next_sub_prev;
    logic [pis_pkg::TICK_CNT_W-1:0] count;
    logic [pis_pkg::TICK_CNT_W-1:0] next_count;
    logic [pis_pkg::TICK_CNT_W-1:0] limit;
    logic                           tick;
    logic                           next_tick;
    logic                           psc_en;

    assign tb.tick = tick;

    always_comb begin
        next_div4_cnt = div4_cnt + 2'h1;
        next_sub_prev = tb.sub_level;
        // Source select: system clock, system clock / 4, subsidiary.
        if (tb.source[pis_pkg::PSC_SUB_BIT]) begin
            psc_en = tb.sub_level & ~sub_prev;
        end else if (tb.source == pis_pkg::PSC_SYS) begin
            psc_en = 1'b1;
        end else begin
            psc_en = (div4_cnt == 2'(pis_pkg::PSC_DIV4 - 1));
        end
        // Period of 2^(8+code) prescaled clocks.
        limit = pis_pkg::TICK_CNT_W'((17'h1 << (pis_pkg::TICK_MIN_EXP
                + int'(tb.period))) - 17'h1);
        next_count = count;
        next_tick  = 1'b0;
        if (!tb.tick_on) begin
            next_count = '0;
        end else if (psc_en) begin
            // A shortened period mid-count ends at once rather than wrap.
            if (count >= limit) begin
                next_count = '0;
                next_tick  = 1'b1;
            end else begin
                next_count = count + 15'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div4_cnt <= 2'h0;
            sub_prev <= 1'b0;
            count    <= 15'h0000;
            tick     <= 1'b0;
        end else begin
            div4_cnt <= next_div4_cnt;
            sub_prev <= next_sub_prev;
            count    <= next_count;
            tick     <= next_tick;
        end
    end

endmodule

`default_nettype wire

// ===== design/pis_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pis_tick_if;
    logic       tick_on;
    logic [2:0] period;
    logic [1:0] source;
    logic       sub_level;
    logic       tick;

    modport ctrl    (output tick_on, output period, output source,
                     output sub_level, input tick);
    modport divider (input tick_on, input period, input source,
                     input sub_level, output tick);
endinterface

`default_nettype wire

// ===== verification/pis_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module pis_core_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Vector call handshake
    input  wire logic       irq_request,
    input  wire logic [3:0] ack_delay,
    output logic            irq_ack
);
    logic [3:0] wait_cnt;

    // The core waits a chosen number of cycles, then takes the call for
    // one cycle; it never answers a request that is not raised.
    always @(negedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (irq_request && !irq_ack) begin
            irq_ack  <= (wait_cnt >= ack_delay);
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            irq_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end
    end
endmodule

`default_nettype wire

// ===== verification/test_peripheral_interrupt_sources.sv
`timescale 1ns/1ps
`default_nettype none

module test_peripheral_interrupt_sources;
    logic core_clk = 1'b0, reset_n = 1'b0, gie_write = 1'b0, gie_wdata = 1'b1;
    logic stack_full = 1'b0, subsidiary_clock = 1'b0, eeprom_cycle_done = 1'b0;
    logic low_voltage_detect = 1'b0, motor_trip_signal = 1'b0;
    logic periodic_tick_control = 1'b0;
    logic ext_pin, filter_input_pin, current_cmp_event;
    logic hall_filtered_a, hall_filtered_b, hall_filtered_c;
    logic group0_enable, hall_a_enable, hall_b_enable, hall_c_enable;
    logic ext_pin_enable, cmp_zero_enable, filter_input_enable;
    logic low_voltage_enable, motor_trip_enable, serial_irq_enable;
    logic eeprom_done_enable, tick_irq_enable;
    logic [5:0]  serial_conditions = 6'h00;
    logic [1:0]  hall_edge_select_reg, ext_edge_select_reg;
    logic [1:0]  cmp_edge_field, filter_edge_field;
    logic [1:0]  prescaler_source_field = 2'h0;
    logic [2:0]  tick_period_field = 3'h0;
    logic [11:0] flag_set = 12'h000, flag_clear = 12'h000, flags;
    logic [3:0]  irq_vector, ack_delay = 4'h0, sub_cnt = 4'h0;
    logic irq_request, irq_ack, wake_request, global_irq_enable;
    logic hall_a_flag, hall_b_flag, hall_c_flag, group0_flag, ext_pin_flag;
    logic cmp_zero_flag, filter_input_flag, low_voltage_flag;
    logic motor_trip_flag, serial_irq_flag, eeprom_done_flag, tick_flag;
    int   num_errors = 0, n_tests = 0;

    assign flags = {tick_flag, eeprom_done_flag, serial_irq_flag,
                    motor_trip_flag, low_voltage_flag, filter_input_flag,
                    cmp_zero_flag, ext_pin_flag, group0_flag, hall_c_flag,
                    hall_b_flag, hall_a_flag};

    always #20 core_clk = ~core_clk;
    // Slow clock of eight core cycles, steady so the tick period is exact.
    always @(negedge core_clk) begin
        sub_cnt <= sub_cnt + 4'h1;
        subsidiary_clock <= sub_cnt[2];
    end

    pis_irq_ctrl pis_irq_ctrl_i (.*);
    pis_core_model pis_core_model_i (.core_clk(core_clk), .reset_n(reset_n),
        .irq_request(irq_request), .ack_delay(ack_delay), .irq_ack(irq_ack));

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic en_all(logic v);
        {group0_enable, hall_a_enable, hall_b_enable, hall_c_enable,
         ext_pin_enable, cmp_zero_enable, filter_input_enable,
         low_voltage_enable, motor_trip_enable, serial_irq_enable,
         eeprom_done_enable, tick_irq_enable} = {12{v}};
    endtask

    task automatic edge_in(logic [1:0] sel, logic v);
        {hall_edge_select_reg, ext_edge_select_reg, cmp_edge_field,
         filter_edge_field} = {4{sel}};
        {hall_filtered_a, hall_filtered_b, hall_filtered_c, ext_pin,
         filter_input_pin, current_cmp_event} = {6{v}};
    endtask

    task automatic clr();
        @(negedge core_clk);
        flag_clear = 12'hFFF;
        @(negedge core_clk);
        flag_clear = 12'h000;
    endtask

    task automatic t_edges();
        logic hit;
        for (int s = 0; s < 4; s++) begin
            for (int v = 1; v >= 0; v--) begin
                clr();
                edge_in(2'(s), v[0]);
                repeat (5) @(negedge core_clk);
                hit = v[0] ? s[0] : s[1];
                check("edge", {7{hit}}, flags[6:0]);
                check("wake", hit, wake_request);
                check("request", 1'b0, irq_request);
            end
        end
        $display("edge test done");
    endtask

    task automatic t_events();
        for (int i = 0; i < 6; i++) begin
            clr();
            serial_conditions = 6'h01 << i;
            {low_voltage_detect, motor_trip_signal, eeprom_cycle_done} = 3'h7;
            @(negedge core_clk);
            {serial_conditions, low_voltage_detect, motor_trip_signal,
             eeprom_cycle_done} = 9'h000;
            repeat (2) @(negedge core_clk);
            check("events", 4'hF, flags[10:7]);
        end
        $display("event test done");
    endtask

    task automatic t_service();
        int n, f;
        en_all(1'b1);
        stack_full = 1'b1;
        clr();
        flag_set = 12'hFFF;
        @(negedge core_clk);
        flag_set = 12'h000;
        repeat (3) @(negedge core_clk);
        check("request", 1'b0, irq_request);
        for (int v = 0; v < pis_pkg::NUM_SRC; v++) begin
            ack_delay = 4'(v % 3);
            f = pis_pkg::FL_SRC_BASE + v;
            gie_write = 1'b1;
            @(negedge core_clk);
            gie_write = 1'b0;
            if (v == 0) begin
                repeat (3) @(negedge core_clk);
                check("stack full", 1'b0, irq_request);
                stack_full = 1'b0;
            end
            n = 0;
            // Look just after the core's edge, when ack and request settle.
            do begin
                @(negedge core_clk);
                #1;
                n++;
            end while (!(irq_ack && irq_request) && n < 40);
            check("ack wait", 1'b1, n < 40);
            check("vector", 16'(v), irq_vector);
            @(negedge core_clk);
            check("gie", 1'b0, global_irq_enable);
            check("served", 1'b0, flags[f]);
        end
        check("hall flags", 3'h7, flags[2:0]);
        $display("service test done");
    endtask

    task automatic t_tick();
        int n, e;
        logic [1:0] src [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
        periodic_tick_control = 1'b1;
        for (int k = 0; k < 4; k++) begin
            prescaler_source_field = src[k];
            tick_period_field = 3'(k == 2);
            e = (1 << (pis_pkg::TICK_MIN_EXP + (k == 2)))
                * (k == 1 ? pis_pkg::PSC_DIV4 : (k == 3 ? 8 : 1));
            for (int w = 0; w < 2; w++) begin
                clr();
                n = 2;
                while (tick_flag !== 1'b1 && n < 5000) begin
                    @(negedge core_clk);
                    n++;
                end
            end
            check("tick", 16'(e), 16'(n));
        end
        $display("tick test done");
    endtask

    initial begin
        en_all(1'b0);
        edge_in(2'h0, 1'b0);
        repeat (8) @(negedge core_clk);
        reset_n = 1'b1;
        t_edges();
        t_events();
        t_service();
        t_tick();
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
endmodule

`default_nettype wire
